//--- rtl/rsr_cfg.svh
// register offsets, field positions and state codes for the receiver status readout
`ifndef RSR_CFG_SVH
`define RSR_CFG_SVH
`define RSR_OFS_STATE 6'h35
`define RSR_OFS_PKT 6'h38
`define RSR_OFS_RXB 6'h3b
`define RSR_PKT_CHK_BIT 7
`define RSR_PKT_CS_BIT 6
`define RSR_PKT_SFD_BIT 3
`define RSR_PKT_PINB_BIT 2
`define RSR_PKT_PINA_BIT 0
`define RSR_RXB_OVF_BIT 7
`define RSR_ST_SLEEP 5'h00
`define RSR_ST_IDLE 5'h01
`define RSR_ST_CRYSTAL_OFF_STATE 5'h02
`define RSR_ST_RX 5'h0d
`define RSR_ST_RX_END 5'h0e
`define RSR_ST_RX_RST 5'h0f
`define RSR_ST_OVF 5'h11
`endif

//--- rtl/rsr_pkg.sv
// types shared by the receiver status readout
package rsr_pkg;
  typedef logic [4:0] rsr_state_t;
  typedef logic [6:0] rsr_count_t;
  typedef logic [7:0] rsr_byte_t;
  typedef logic [5:0] rsr_addr_t;
endpackage

//--- rtl/rsr_flag_if.sv
// packet flag bundle passed from the flag tracker to the readout
`timescale 1ns/1ps
interface rsr_flag_if;
  logic chk_ok;
  logic carrier;
  logic frame_delimiter_flag;
  modport src (output chk_ok, output carrier, output frame_delimiter_flag);
  modport dst (input chk_ok, input carrier, input frame_delimiter_flag);
endinterface

//--- rtl/rsr_flag_track.sv
// packet status flag tracker: checksum match, carrier sense, frame delimiter
`timescale 1ns/1ps
`include "rsr_cfg.svh"
module rsr_flag_track (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire rsr_pkg::rsr_state_t state,
  input wire logic chk_done,
  input wire logic chk_match,
  input wire logic carrier_in,
  input wire logic sync_found,
  input wire logic pkt_end,
  input wire logic pkt_drop,
  rsr_flag_if.src flags
);
  import rsr_pkg::*;
  rsr_state_t state_reg;
  logic chk_reg, cs_reg, sfd_reg;
  logic rx_entry, idle_entry, ovf_entry;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `RSR_ST_SLEEP;
    end else if (ce) begin
      state_reg <= state;
    end
  end

  // restart passes through the rx reset code, so entering it also counts
  assign rx_entry = (state != state_reg) &&
      (state == `RSR_ST_RX || state == `RSR_ST_RX_RST);
  assign idle_entry = (state == `RSR_ST_IDLE) && (state_reg != `RSR_ST_IDLE);
  assign ovf_entry = (state == `RSR_ST_OVF) && (state_reg != `RSR_ST_OVF);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_reg <= 1'b0;
    end else if (ce) begin
      if (rx_entry) begin
        chk_reg <= 1'b0;
      end else if (chk_done) begin
        chk_reg <= chk_match;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_reg <= 1'b0;
    end else if (ce) begin
      cs_reg <= idle_entry ? 1'b0 : carrier_in;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfd_reg <= 1'b0;
    end else if (ce) begin
      if (pkt_end || pkt_drop || ovf_entry) begin
        sfd_reg <= 1'b0;
      end else if (sync_found) begin
        sfd_reg <= 1'b1;
      end
    end
  end

  assign flags.chk_ok = chk_reg;
  assign flags.carrier = cs_reg;
  assign flags.frame_delimiter_flag = sfd_reg;
endmodule

//--- rtl/rsr_top.sv
// receiver status readout: state code, packet/pin status and rx fill registers
// Operation
// - state code register reports the 5-bit radio control state, upper bits zero
// - bit 7 shows last checksum match, cleared on entering or restarting receive
// - bit 6 shows carrier sense, cleared on entering idle
// - bit 3 sets on sync word received, clears at packet end
// - bit 3 also clears on filter drop or entering overflow state
// - bit 2 shows second output pin level, non-inverted
// - bit 0 shows first output pin level, non-inverted
// - fill register: overflow flag bit 7, byte count bits 6:0
`timescale 1ns/1ps
`include "rsr_cfg.svh"
module rsr_top (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire rsr_pkg::rsr_state_t RADIO_STATE,
  input wire logic CHK_DONE,
  input wire logic CHK_MATCH,
  input wire logic CARRIER,
  input wire logic SYNC_FOUND,
  input wire logic PKT_END,
  input wire logic PKT_DROP,
  input wire logic OUTPUT_PIN_A_LEVEL,
  input wire logic OUTPUT_PIN_B_LEVEL,
  input wire logic OUTPUT_PIN_A_INVERT,
  input wire logic OUTPUT_PIN_B_INVERT,
  input wire logic RX_OVERFLOW_EVT,
  input wire logic RX_FLUSH,
  input wire rsr_pkg::rsr_count_t RX_FILL_COUNT,
  input wire logic RD_EN,
  input wire logic WR_EN,
  input wire rsr_pkg::rsr_addr_t ADDR,
  input wire rsr_pkg::rsr_byte_t WDATA,
  output logic [7:0] RDATA,
  output logic RVALID
);
  import rsr_pkg::*;
  rsr_flag_if flags ();
  logic ovf_reg;
  logic pin_a_raw, pin_b_raw;
  rsr_byte_t rdata_next;

  rsr_flag_track u_track (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .state(RADIO_STATE),
    .chk_done(CHK_DONE),
    .chk_match(CHK_MATCH),
    .carrier_in(CARRIER),
    .sync_found(SYNC_FOUND),
    .pkt_end(PKT_END),
    .pkt_drop(PKT_DROP),
    .flags(flags)
  );

  // pin levels arrive as driven on the pad; undo the inversion so the read
  // shows the internal signal, which is why it is a poor lock indicator
  assign pin_a_raw = OUTPUT_PIN_A_LEVEL ^ OUTPUT_PIN_A_INVERT;
  assign pin_b_raw = OUTPUT_PIN_B_LEVEL ^ OUTPUT_PIN_B_INVERT;

  // set beats flush in the same cycle so an overflow is not lost to a flush; a pulse while CE is low is dropped
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ovf_reg <= 1'b0;
    end else if (CE) begin
      if (RX_OVERFLOW_EVT) begin
        ovf_reg <= 1'b1;
      end else if (RX_FLUSH) begin
        ovf_reg <= 1'b0;
      end
    end
  end

  // write strobe and data are accepted but nothing is stored
  always_comb begin
    rdata_next = 8'h00;
    if (ADDR == `RSR_OFS_STATE) begin
      rdata_next = {3'h0, RADIO_STATE};
    end else if (ADDR == `RSR_OFS_PKT) begin
      rdata_next[`RSR_PKT_CHK_BIT] = flags.chk_ok;
      rdata_next[`RSR_PKT_CS_BIT] = flags.carrier;
      rdata_next[`RSR_PKT_SFD_BIT] = flags.frame_delimiter_flag;
      rdata_next[`RSR_PKT_PINB_BIT] = pin_b_raw;
      rdata_next[`RSR_PKT_PINA_BIT] = pin_a_raw;
    end else if (ADDR == `RSR_OFS_RXB) begin
      rdata_next = {ovf_reg, RX_FILL_COUNT};
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
      RVALID <= 1'b0;
    end else if (CE) begin
      RVALID <= RD_EN;
      if (RD_EN) begin
        RDATA <= rdata_next;
      end
    end
  end
endmodule

//--- dv/rsr_props.sv
// port assertions for the receiver status readout
`timescale 1ns/1ps
module rsr_props (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic RD_EN,
  input wire rsr_pkg::rsr_addr_t ADDR,
  input wire rsr_pkg::rsr_state_t RADIO_STATE,
  input wire rsr_pkg::rsr_count_t RX_FILL_COUNT,
  input wire logic [7:0] RDATA,
  input wire logic RVALID
);
  wire logic rd = CE && RD_EN;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  a_read_ack: assert property (rd |=> RVALID) else $error("no ack");
  a_ack_once: assert property (CE && !RD_EN |=> !RVALID) else $error("long ack");
  a_ack_cause: assert property (RVALID && $past(CE) |-> $past(rd)) else $error("ack");
  a_data_hold: assert property (!rd |=> $stable(RDATA)) else $error("data moved");
  a_freeze_hold: assert property (!CE |=> $stable(RVALID)) else $error("ack moved");
  a_ovf_bit: assert property (rd && ADDR == 6'h3b |=>
    RVALID && RDATA[7] !== 1'bx) else $error("ovf bit");
  a_state_read: assert property (rd && ADDR == 6'h35 |=>
    RDATA == {3'h0, $past(RADIO_STATE)}) else $error("state");
  a_fill_read: assert property (rd && ADDR == 6'h3b |=>
    RDATA[6:0] == $past(RX_FILL_COUNT)) else $error("fill");
  a_pkt_zero: assert property (rd && ADDR == 6'h38 |=>
    RDATA[5:4] == 2'h0 && !RDATA[1]) else $error("spare bits");
  a_unmapped_zero: assert property (rd && !(ADDR inside {6'h35, 6'h38, 6'h3b}) |=>
    RDATA == 8'h00) else $error("unmapped");
endmodule

//--- dv/rsr_host.sv
// host model that reads status registers one byte at a time
`timescale 1ns/1ps
module rsr_host (
  input wire logic clk,
  output logic rd_en,
  output rsr_pkg::rsr_addr_t addr,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  import rsr_pkg::*;
  initial {rd_en, addr} = 7'h00;
  // pin bits are read back only, never polled to wait for synth lock
  task automatic rd(input rsr_addr_t a, output logic [8:0] r);
    @(negedge clk) {rd_en, addr} = {1'b1, a};
    // released address shows the inverse so a stale decode cannot pass
    @(negedge clk) {rd_en, addr} = {1'b0, ~a};
    r = {rvalid, rdata};
  endtask
endmodule

//--- dv/tb_top.sv
// self-checking bench for the receiver status readout
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected %0t got %h", $time, a); end end
module tb_top;
  bit REF_CLK, RST_N, CE = 1'b1, CHK_DONE, CHK_MATCH = 1'b1, CARRIER, SYNC_FOUND, PKT_END;
  bit PKT_DROP, RX_OVERFLOW_EVT, RX_FLUSH, WR_EN, OUTPUT_PIN_A_LEVEL, OUTPUT_PIN_B_LEVEL;
  bit OUTPUT_PIN_A_INVERT, OUTPUT_PIN_B_INVERT;
  bit [4:0] RADIO_STATE;
  bit [6:0] RX_FILL_COUNT = 7'h7f;
  bit [7:0] WDATA = 8'hff;
  logic RD_EN, RVALID;
  logic [5:0] ADDR;
  logic [7:0] RDATA;
  logic [8:0] r;
  int n_fail, checked, cyc;
  rsr_top u_dut (.*);
  rsr_host u_host (.clk(REF_CLK), .rd_en(RD_EN), .addr(ADDR), .rdata(RDATA), .rvalid(RVALID));
  initial forever #50 REF_CLK = ~REF_CLK;
  task automatic pulse(ref bit s);
    @(negedge REF_CLK) s = 1'b1;
    @(negedge REF_CLK) s = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    u_host.rd(a, r);
    `CHK(r, {1'b1, e})
  endtask
  task automatic t_pins;
    for (int j = 0; j < 16; j++) begin
      {OUTPUT_PIN_B_INVERT, OUTPUT_PIN_B_LEVEL, OUTPUT_PIN_A_INVERT, OUTPUT_PIN_A_LEVEL} = 4'(j);
      rd(6'h38, {5'h00, ^2'(j >> 2), 1'b0, ^2'(j)});
    end
  endtask
  task automatic t_state;
    for (int j = 0; j < 18; j++) begin
      @(negedge REF_CLK) RADIO_STATE = 5'(j);
      rd(6'h35, 8'(j));
    end
  endtask
  task automatic t_flags;
    @(negedge REF_CLK) RADIO_STATE = 5'h0d;
    pulse(CHK_DONE);
    rd(6'h38, 8'h80);
    CHK_MATCH = 1'b0;
    pulse(CHK_DONE);
    rd(6'h38, 8'h00);
    @(negedge REF_CLK) RADIO_STATE = 5'h0f;
    pulse(SYNC_FOUND);
    rd(6'h38, 8'h08);
    pulse(PKT_DROP);
    CARRIER = 1'b1;
    rd(6'h38, 8'h40);
    pulse(SYNC_FOUND);
    @(negedge REF_CLK) RADIO_STATE = 5'h01;
    rd(6'h38, 8'h08);
    @(negedge REF_CLK) {RADIO_STATE, CARRIER} = {5'h11, 1'b0};
    rd(6'h38, 8'h00);
    pulse(SYNC_FOUND);
    rd(6'h38, 8'h08);
    pulse(PKT_END);
    rd(6'h38, 8'h00);
  endtask
  // an overflow pulse while frozen must be lost, and a read must not answer
  task automatic t_freeze;
    @(negedge REF_CLK) CE = 1'b0;
    pulse(RX_OVERFLOW_EVT);
    u_host.rd(6'h3b, r);
    `CHK(r, 9'h000)
    @(negedge REF_CLK) CE = 1'b1;
    rd(6'h3b, 8'h7f);
  endtask
  task automatic t_fill;
    pulse(RX_OVERFLOW_EVT);
    pulse(WR_EN);
    rd(6'h3b, 8'hff);
    pulse(RX_FLUSH);
    rd(6'h3b, 8'h7f);
    rd(6'h3c, 8'h00);
  endtask
  initial begin
    repeat (10) @(negedge REF_CLK);
    RST_N = 1'b1;
    t_pins;
    t_state;
    t_flags;
    t_fill;
    t_freeze;
    final_report;
  end
  always @(posedge REF_CLK) if (++cyc == 2000) begin
    n_fail++;
    final_report;
  end
  task automatic final_report;
    if (n_fail == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
endmodule
bind rsr_top rsr_props u_props (.REF_CLK, .RST_N, .CE, .RD_EN, .ADDR, .RADIO_STATE,
  .RX_FILL_COUNT, .RDATA, .RVALID);
